// file: shared/blm_pkg.sv
// package of constants and types for the button and lamp mode controller
package blm_pkg;
   // ==========================================================
   // timing
   // ==========================================================
   localparam int unsigned CLK_HZ          = 125_000_000;
   localparam int unsigned TICK_US         = 1000;
   localparam int unsigned TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;
   localparam int unsigned SEARCH_SEC      = 10;
   localparam int unsigned SEARCH_MS       = SEARCH_SEC * 1000;
   localparam int unsigned CANCEL_SEC      = 1;
   localparam int unsigned CANCEL_MS       = CANCEL_SEC * 1000;
   localparam int unsigned PAIR_SEC        = 5;
   localparam int unsigned PAIR_MS         = PAIR_SEC * 1000;
   localparam int unsigned LINK_BLINK_MS   = 300;
   localparam int unsigned BATT_BLINK_MS   = 1000;
   localparam int unsigned DEBOUNCE_MS     = 20;
   localparam int unsigned MS_W            = 14;
   localparam int unsigned PEER_W          = 3;
   localparam logic [PEER_W-1:0] PEER_CNT_DEF = 3'h7;

   // ==========================================================
   // states
   // ==========================================================
   typedef enum logic [1:0] {
      ST_STANDBY    = 2'b00,
      ST_CONNECTING = 2'b01,
      ST_PAIRING    = 2'b10,
      ST_ACTIVE     = 2'b11
   } blm_mode_e;

   typedef enum logic [1:0] {
      BAT_FULL     = 2'b00,
      BAT_LOW      = 2'b01,
      BAT_CHARGING = 2'b10
   } blm_batt_e;
endpackage

// file: shared/blm_tick_if.sv
// interface carrying the millisecond tick and debounced button
`timescale 1ns/1ps
`default_nettype none
interface blm_tick_if;
   logic tick;
   logic btn;
   modport src (output tick, output btn);
   modport dst (input tick, input btn);
endinterface
`default_nettype wire

// file: rtl/blm_tick_gen.sv
// millisecond tick generator and button debouncer
`timescale 1ns/1ps
`default_nettype none
module blm_tick_gen #(
   parameter int unsigned TICK_CYC = blm_pkg::TICK_CYC
) (
   input  wire logic clock_i,
   input  wire logic rst_b_i,
   input  wire logic clk_en_i,
   input  wire logic btn_sync_i,
   blm_tick_if.src   tk
);
   typedef struct packed {
      logic [16:0] div;
      logic        tick;
      logic [4:0]  stable;
      logic        btn;
   } blm_tg_s;

   blm_tg_s r_ff;
   blm_tg_s nxt_r;

   always_comb begin
      nxt_r      = r_ff;
      nxt_r.tick = 1'b0;
      if (r_ff.div == 17'(TICK_CYC - 1)) begin
         nxt_r.div  = '0;
         nxt_r.tick = 1'b1;
      end else begin
         nxt_r.div = r_ff.div + 17'h1;
      end
      // debounce: accept level after a quiet spell of ticks
      if (btn_sync_i == r_ff.btn) begin
         nxt_r.stable = '0;
      end else if (r_ff.tick) begin
         if (r_ff.stable == 5'(blm_pkg::DEBOUNCE_MS - 1)) begin
            nxt_r.btn    = btn_sync_i;
            nxt_r.stable = '0;
         end else begin
            nxt_r.stable = r_ff.stable + 5'h1;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r_ff <= '0;
      end else if (clk_en_i) begin
         r_ff <= nxt_r;
      end
   end

   assign tk.tick = r_ff.tick;
   assign tk.btn  = r_ff.btn;
endmodule
`default_nettype wire

// file: rtl/blm_ctrl.sv
// mode controller: button, peer search timing and indicator lamps
`timescale 1ns/1ps
`default_nettype none
module blm_ctrl #(
   parameter int unsigned          TICK_CYC  = blm_pkg::TICK_CYC,
   parameter logic [blm_pkg::PEER_W-1:0] PEER_CNT = blm_pkg::PEER_CNT_DEF
) (
   input  wire logic                        clock_i,
   input  wire logic                        rst_b_i,
   input  wire logic                        clk_en_i,
   input  wire logic                        button_input_pin_i,
   input  wire logic                        link_up_i,
   input  wire logic                        batt_low_i,
   input  wire logic                        batt_charging_i,
   output var  logic                        link_lamp_o,
   output var  logic                        receiver_power_lamp_o,
   output var  logic                        battery_lamp_o,
   output var  logic                        peer_try_o,
   output var  logic [blm_pkg::PEER_W-1:0]  peer_idx_o,
   output var  logic                        pair_mode_o,
   output var  logic                        receiver_power_o
);
   typedef struct packed {
      logic [1:0]                sync;
      logic [1:0]                lsync;
      logic [1:0]                bsync;
      logic [1:0]                csync;
      logic                      btn_q;
      blm_pkg::blm_mode_e        mode;
      logic [blm_pkg::MS_W-1:0]  hold_ms;
      logic                      hold_used;
      logic [blm_pkg::MS_W-1:0]  search_ms;
      logic [blm_pkg::PEER_W-1:0] peer;
      logic [9:0]                lblink;
      logic                      lphase;
      logic [9:0]                bblink;
      logic                      bphase;
      logic                      link_lamp;
      logic                      pwr_lamp;
      logic                      batt_lamp;
      logic                      try;
      logic                      pair;
   } blm_ctrl_s;

   blm_ctrl_s r_ff;
   blm_ctrl_s nxt_r;

   blm_tick_if tk ();

   blm_tick_gen #(
      .TICK_CYC (TICK_CYC)
   ) u_tick (
      .clock_i    (clock_i),
      .rst_b_i    (rst_b_i),
      .clk_en_i   (clk_en_i),
      .btn_sync_i (r_ff.sync[1]),
      .tk         (tk.src)
   );

   // ==========================================================
   // next state
   // ==========================================================
   logic press;
   logic release_ev;
   logic link_up;

   always_comb begin
      press      = tk.btn & ~r_ff.btn_q;
      release_ev = ~tk.btn & r_ff.btn_q;
      link_up    = r_ff.lsync[1];
      nxt_r      = r_ff;
      nxt_r.sync  = {r_ff.sync[0], button_input_pin_i};
      nxt_r.lsync = {r_ff.lsync[0], link_up_i};
      nxt_r.bsync = {r_ff.bsync[0], batt_low_i};
      nxt_r.csync = {r_ff.csync[0], batt_charging_i};
      nxt_r.btn_q = tk.btn;

      // hold timer, counts held milliseconds
      if (press) begin
         nxt_r.hold_ms   = '0;
         nxt_r.hold_used = 1'b0;
      end else if (tk.btn && tk.tick &&
                   r_ff.hold_ms != {blm_pkg::MS_W{1'b1}}) begin
         nxt_r.hold_ms = r_ff.hold_ms + blm_pkg::MS_W'(1);
      end

      unique case (r_ff.mode)
         blm_pkg::ST_STANDBY: begin
            if (tk.btn && !r_ff.hold_used &&
                r_ff.hold_ms >= blm_pkg::MS_W'(blm_pkg::PAIR_MS)) begin
               nxt_r.mode      = blm_pkg::ST_PAIRING;
               nxt_r.hold_used = 1'b1;
            end else if (release_ev && !r_ff.hold_used) begin
               nxt_r.mode      = blm_pkg::ST_CONNECTING;
               nxt_r.peer      = '0;
               nxt_r.search_ms = '0;
            end
         end
         blm_pkg::ST_CONNECTING: begin
            if (link_up) begin
               nxt_r.mode = blm_pkg::ST_ACTIVE;
            end else if (tk.btn && !r_ff.hold_used &&
                r_ff.hold_ms >= blm_pkg::MS_W'(blm_pkg::CANCEL_MS)) begin
               nxt_r.mode      = blm_pkg::ST_STANDBY;
               nxt_r.hold_used = 1'b1;
            end else if (tk.tick) begin
               if (r_ff.search_ms ==
                   blm_pkg::MS_W'(blm_pkg::SEARCH_MS - 1)) begin
                  nxt_r.search_ms = '0;
                  if (r_ff.peer == PEER_CNT - blm_pkg::PEER_W'(1)) begin
                     nxt_r.mode = blm_pkg::ST_STANDBY;
                  end else begin
                     nxt_r.peer = r_ff.peer + blm_pkg::PEER_W'(1);
                  end
               end else begin
                  nxt_r.search_ms = r_ff.search_ms + blm_pkg::MS_W'(1);
               end
            end
         end
         blm_pkg::ST_PAIRING: begin
            if (link_up) begin
               nxt_r.mode = blm_pkg::ST_ACTIVE;
            end
         end
         blm_pkg::ST_ACTIVE: begin
            if (!link_up) begin
               nxt_r.mode = blm_pkg::ST_STANDBY;
            end
         end
      endcase
      // presses in pairing or active never start a search later
      if (press && (r_ff.mode == blm_pkg::ST_PAIRING ||
                    r_ff.mode == blm_pkg::ST_ACTIVE)) begin
         nxt_r.hold_used = 1'b1;
      end
      if (press && r_ff.mode == blm_pkg::ST_STANDBY) begin
         nxt_r.hold_used = 1'b0;
      end

      // link lamp blink timebase
      if (r_ff.mode != blm_pkg::ST_CONNECTING) begin
         nxt_r.lblink = '0;
         nxt_r.lphase = 1'b1;
      end else if (tk.tick) begin
         if (r_ff.lblink == 10'(blm_pkg::LINK_BLINK_MS - 1)) begin
            nxt_r.lblink = '0;
            nxt_r.lphase = ~r_ff.lphase;
         end else begin
            nxt_r.lblink = r_ff.lblink + 10'h1;
         end
      end

      // battery lamp blink timebase
      if (tk.tick) begin
         if (r_ff.bblink == 10'(blm_pkg::BATT_BLINK_MS - 1)) begin
            nxt_r.bblink = '0;
            nxt_r.bphase = ~r_ff.bphase;
         end else begin
            nxt_r.bblink = r_ff.bblink + 10'h1;
         end
      end

      // lamps from the state about to be entered
      unique case (nxt_r.mode)
         blm_pkg::ST_STANDBY: begin
            nxt_r.link_lamp = 1'b0;
            nxt_r.pwr_lamp  = 1'b0;
         end
         blm_pkg::ST_PAIRING: begin
            nxt_r.link_lamp = 1'b1;
            nxt_r.pwr_lamp  = 1'b0;
         end
         blm_pkg::ST_CONNECTING: begin
            nxt_r.link_lamp = nxt_r.lphase;
            nxt_r.pwr_lamp  = 1'b0;
         end
         blm_pkg::ST_ACTIVE: begin
            nxt_r.link_lamp = 1'b1;
            nxt_r.pwr_lamp  = 1'b1;
         end
      endcase
      // charging wins over low: lamp steady on
      if (r_ff.csync[1]) begin
         nxt_r.batt_lamp = 1'b1;
      end else if (r_ff.bsync[1]) begin
         nxt_r.batt_lamp = nxt_r.bphase;
      end else begin
         nxt_r.batt_lamp = 1'b0;
      end
      nxt_r.try  = (nxt_r.mode == blm_pkg::ST_CONNECTING);
      nxt_r.pair = (nxt_r.mode == blm_pkg::ST_PAIRING);
   end

   // ==========================================================
   // state register
   // ==========================================================
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r_ff        <= '0;
         r_ff.mode   <= blm_pkg::ST_STANDBY;
         r_ff.lphase <= 1'b1;
         r_ff.bphase <= 1'b1;
      end else if (clk_en_i) begin
         r_ff <= nxt_r;
      end
   end

   assign link_lamp_o           = r_ff.link_lamp;
   assign receiver_power_lamp_o = r_ff.pwr_lamp;
   assign battery_lamp_o        = r_ff.batt_lamp;
   assign peer_try_o            = r_ff.try;
   assign peer_idx_o            = r_ff.peer;
   assign pair_mode_o           = r_ff.pair;
   assign receiver_power_o      = r_ff.pwr_lamp;
endmodule
`default_nettype wire

// file: tb/blm_user.sv
// behavioural model of the user pressing the button
`timescale 1ns/1ps
`default_nettype none
module blm_user (
   input  wire logic clock_i,
   output var  logic button_o
);
   // ==========================================================
   // button actions, launched just after a rising edge
   // ==========================================================
   initial button_o = 1'b0;
   task automatic push();
      @(posedge clock_i);
      button_o <= 1'b1;
   endtask
   task automatic let_go();
      @(posedge clock_i);
      button_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: tb/blm_ctrl_asserts.sv
// port assertions for the mode controller
`timescale 1ns/1ps
`default_nettype none
module blm_ctrl_asserts #(
   parameter int unsigned TICK_CYC = blm_pkg::TICK_CYC
) (
   input  wire logic                       clock_i,
   input  wire logic                       rst_b_i,
   input  wire logic                       clk_en_i,
   input  wire logic                       button_input_pin_i,
   input  wire logic                       link_up_i,
   input  wire logic                       batt_low_i,
   input  wire logic                       batt_charging_i,
   input  wire logic                       link_lamp_o,
   input  wire logic                       receiver_power_lamp_o,
   input  wire logic                       battery_lamp_o,
   input  wire logic                       peer_try_o,
   input  wire logic [blm_pkg::PEER_W-1:0] peer_idx_o,
   input  wire logic                       pair_mode_o,
   input  wire logic                       receiver_power_o
);
   // ==========================================================
   // dwell counter per searched peer
   // ==========================================================
   localparam int unsigned WIN = blm_pkg::SEARCH_MS * TICK_CYC;
   int unsigned dwell_ff;
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) dwell_ff <= 0;
      else if (!peer_try_o || $changed(peer_idx_o)) dwell_ff <= 0;
      else if (clk_en_i) dwell_ff <= dwell_ff + 1;
   end
   // ==========================================================
   // properties
   // ==========================================================
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   sequence charge_held; batt_charging_i [*6]; endsequence
   sequence full_held; (!batt_charging_i && !batt_low_i) [*6]; endsequence
   sequence link_gained; peer_try_o && $rose(link_up_i); endsequence
   chk_reset_quiet: assert property ($rose(rst_b_i) |-> !(link_lamp_o
      || receiver_power_lamp_o || battery_lamp_o || peer_try_o
      || receiver_power_o)) else $error("outputs not idle after reset");
   chk_link_win: assert property (link_gained |-> ##[2:8]
      (link_lamp_o && receiver_power_lamp_o && !peer_try_o))
      else $error("link success did not reach active");
   chk_pair_lamps: assert property (pair_mode_o && $past(pair_mode_o)
      |-> link_lamp_o && !receiver_power_lamp_o)
      else $error("pairing lamps wrong");
   chk_active_lamps: assert property (receiver_power_o
      && $past(receiver_power_o) |-> link_lamp_o && receiver_power_lamp_o)
      else $error("active lamps wrong");
   chk_try_dark: assert property (peer_try_o |-> !receiver_power_lamp_o)
      else $error("power lamp lit while searching");
   chk_pair_solo: assert property (pair_mode_o |-> !peer_try_o)
      else $error("pairing and searching together");
   chk_charge_lamp: assert property (charge_held |-> battery_lamp_o)
      else $error("battery lamp dark while charging");
   chk_full_dark: assert property (full_held |-> !battery_lamp_o)
      else $error("battery lamp lit while full");
   chk_dwell_max: assert property (dwell_ff <= WIN + 2 * TICK_CYC)
      else $error("peer search window too long");
   chk_dwell_min: assert property ($changed(peer_idx_o) && peer_try_o
      && $past(peer_try_o) |-> dwell_ff + 2 * TICK_CYC >= WIN)
      else $error("peer search window too short");
endmodule
bind blm_ctrl blm_ctrl_asserts #(.TICK_CYC(TICK_CYC)) u_chk (
   .clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
   .button_input_pin_i(button_input_pin_i), .link_up_i(link_up_i),
   .batt_low_i(batt_low_i), .batt_charging_i(batt_charging_i),
   .link_lamp_o(link_lamp_o), .receiver_power_lamp_o(receiver_power_lamp_o),
   .battery_lamp_o(battery_lamp_o), .peer_try_o(peer_try_o),
   .peer_idx_o(peer_idx_o), .pair_mode_o(pair_mode_o),
   .receiver_power_o(receiver_power_o));
`default_nettype wire

// file: tb/blm_ctrl_test.sv
// self-checking testbench for the mode controller
`timescale 1ns/1ps
`default_nettype none
module blm_ctrl_test;
   localparam int unsigned TK = 2;
   logic                       clock_i, rst_b_i, link_up_i, btn, clk_en;
   logic                       batt_low_i, batt_charging_i;
   logic                       link_lamp, pwr_lamp, bat_lamp;
   logic                       try_o, pair_o, rx_pwr;
   logic [blm_pkg::PEER_W-1:0] idx;
   int                         fail_count = 0;
   int                         checks_done = 0;
   blm_user user (.clock_i(clock_i), .button_o(btn));
   blm_ctrl #(.TICK_CYC(TK)) uut (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en),
      .button_input_pin_i(btn), .link_up_i(link_up_i),
      .batt_low_i(batt_low_i), .batt_charging_i(batt_charging_i),
      .link_lamp_o(link_lamp), .receiver_power_lamp_o(pwr_lamp),
      .battery_lamp_o(bat_lamp), .peer_try_o(try_o), .peer_idx_o(idx),
      .pair_mode_o(pair_o), .receiver_power_o(rx_pwr));
   // ==========================================================
   // helpers
   // ==========================================================
   task automatic chk(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input int got, input int lo, input int hi);
      checks_done++;
      if (got < lo || got > hi) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic wait_on(ref logic s, input logic v, input int lim,
                          output int n);
      n = 0;
      while (s !== v) begin
         @(posedge clock_i);
         #1;
         n++;
         if (n > lim) begin
            chk(s, v);
            final_report();
         end
      end
   endtask
   task automatic link_cycle();
      int n;
      @(posedge clock_i);
      link_up_i <= 1'b1;
      wait_on(rx_pwr, 1'b1, 8, n);
      repeat (2) @(posedge clock_i);
      #1 chk(try_o, 1'b0);
      chk(link_lamp, 1'b1);
      chk(pwr_lamp, 1'b1);
      @(posedge clock_i);
      link_up_i <= 1'b0;
      wait_on(rx_pwr, 1'b0, 8, n);
      repeat (2) @(posedge clock_i);
      #1 chk(link_lamp, 1'b0);
      chk(pwr_lamp, 1'b0);
   endtask
   task automatic start_search();
      int n;
      user.push();
      repeat (50 * TK) @(posedge clock_i);
      user.let_go();
      wait_on(try_o, 1'b1, 40 * TK, n);
   endtask
   // ==========================================================
   // scenarios
   // ==========================================================
   task automatic t_reset();
      chk(link_lamp, 1'b0);
      chk(pwr_lamp, 1'b0);
      chk(bat_lamp, 1'b0);
      chk(try_o, 1'b0);
      chk(pair_o, 1'b0);
      $display("test reset done");
   endtask
   task automatic t_connect();
      int n, m;
      logic [blm_pkg::PEER_W-1:0] first;
      start_search();
      chk(link_lamp, 1'b1);
      chk(pwr_lamp, 1'b0);
      wait_on(link_lamp, 1'b0, 400 * TK, m);
      wait_on(link_lamp, 1'b1, 400 * TK, n);
      chk_rng(n, 300 * TK, 300 * TK);
      m = m + n;
      first = idx;
      while (idx === first && m < 11000 * TK) begin
         @(posedge clock_i);
         #1 m++;
      end
      chk_rng(m, 10000 * TK - 2 * TK, 10000 * TK + 2 * TK);
      link_cycle();
      $display("test connect done");
   endtask
   task automatic t_cancel();
      start_search();
      user.push();
      repeat (1100 * TK) @(posedge clock_i);
      #1 chk(try_o, 1'b0);
      chk(link_lamp, 1'b0);
      user.let_go();
      repeat (100 * TK) @(posedge clock_i);
      #1 chk(try_o, 1'b0);
      $display("test cancel done");
   endtask
   task automatic t_pair();
      user.push();
      repeat (4900 * TK) @(posedge clock_i);
      #1 chk(pair_o, 1'b0);
      repeat (200 * TK) @(posedge clock_i);
      #1 chk(pair_o, 1'b1);
      chk(try_o, 1'b0);
      chk(link_lamp, 1'b1);
      chk(pwr_lamp, 1'b0);
      user.let_go();
      repeat (100 * TK) @(posedge clock_i);
      #1 chk(pair_o, 1'b1);
      // frozen clock enable: link request must not be taken
      @(posedge clock_i);
      clk_en <= 1'b0;
      link_up_i <= 1'b1;
      repeat (20) @(posedge clock_i);
      #1 chk(pair_o, 1'b1);
      chk(rx_pwr, 1'b0);
      @(posedge clock_i);
      clk_en <= 1'b1;
      link_up_i <= 1'b0;
      link_cycle();
      $display("test pair done");
   endtask
   task automatic t_batt();
      int n;
      @(posedge clock_i);
      batt_charging_i <= 1'b1;
      repeat (8) @(posedge clock_i);
      #1 chk(bat_lamp, 1'b1);
      @(posedge clock_i);
      batt_charging_i <= 1'b0;
      batt_low_i <= 1'b1;
      wait_on(bat_lamp, 1'b0, 1100 * TK, n);
      wait_on(bat_lamp, 1'b1, 1100 * TK, n);
      wait_on(bat_lamp, 1'b0, 1100 * TK, n);
      chk_rng(n, 1000 * TK, 1000 * TK);
      @(posedge clock_i);
      batt_charging_i <= 1'b1;
      repeat (8) @(posedge clock_i);
      #1 chk(bat_lamp, 1'b1);
      @(posedge clock_i);
      batt_charging_i <= 1'b0;
      batt_low_i <= 1'b0;
      repeat (8) @(posedge clock_i);
      #1 chk(bat_lamp, 1'b0);
      $display("test battery done");
   endtask
   // ==========================================================
   // clock, reset and sequence
   // ==========================================================
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   initial begin
      rst_b_i = 1'b0;
      clk_en = 1'b1;
      link_up_i = 1'b0;
      batt_low_i = 1'b0;
      batt_charging_i = 1'b0;
      repeat (16) @(posedge clock_i);
      rst_b_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      #1 t_reset();
      t_connect();
      t_cancel();
      t_pair();
      t_batt();
      final_report();
   end
endmodule
`default_nettype wire
